// ---- logic/cms_pkg.sv ----
package cms_pkg;

	// ------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------
	localparam int CLK_HZ = 10_000_000;
	localparam int HOLD_TIME_NS = 3440;
	localparam int HOLD_CYC = (HOLD_TIME_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
	localparam int IO_SD_DLY_MS = 57;
	localparam int IO_SD_DLY_CYC = IO_SD_DLY_MS * (CLK_HZ / 1000);
	localparam int DTEMP_PERIOD_US = 50;
	localparam int DTEMP_CYC = DTEMP_PERIOD_US * (CLK_HZ / 1_000_000);
	localparam int VCORE_PERIOD_US = 30;
	localparam int VCORE_CYC = VCORE_PERIOD_US * (CLK_HZ / 1_000_000);

	// ------------------------------------------------------------
	// channels
	// ------------------------------------------------------------
	localparam int NCH = 30;
	localparam int NCELL = 16;
	localparam int CH_AUX0 = 16;
	localparam int CH_MODULE = 24;
	localparam int CH_VCORE = 28;
	localparam int CH_DTEMP = 29;
	localparam int MAX_OVS_CODE = 5;

	// ------------------------------------------------------------
	// register byte offsets and reset values
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_CMD = 8'h00;
	localparam logic [7:0] OFS_CELL_COUNT = 8'h04;
	localparam logic [7:0] OFS_CHAN_SEL = 8'h08;
	localparam logic [7:0] OFS_OVS_CFG = 8'h0C;
	localparam logic [7:0] OFS_PER_CELL = 8'h10;
	localparam logic [7:0] OFS_PER_AUX = 8'h14;
	localparam logic [7:0] OFS_PER_INT = 8'h18;
	localparam logic [7:0] OFS_OFF_CELL = 8'h1C;
	localparam logic [7:0] OFS_OFF_AUX = 8'h20;
	localparam logic [7:0] OFS_STATUS = 8'h24;
	localparam logic [7:0] OFS_SHUTDOWN_STATUS = 8'h28;
	localparam logic [7:0] OFS_RESULT0 = 8'h40;
	localparam logic [7:0] CELL_COUNT_RST = 8'h10;
	localparam logic [29:0] CHAN_SEL_RST = 30'h0000FFFF;
	localparam logic [15:0] PER_CELL_RST = 16'h0258;
	localparam logic [15:0] PER_AUX_RST = 16'h007E;
	localparam logic [15:0] PER_INT_RST = 16'h03E8;
	localparam logic [15:0] OVS_HPER_RST = 16'h007E;
	localparam logic [15:0] OVS_GPER_RST = 16'h007E;

	// ------------------------------------------------------------
	// types
	// ------------------------------------------------------------
	typedef enum logic [3:0] {
		SQ_IDLE = 4'b0001,
		SQ_ACQ = 4'b0010,
		SQ_HOLD = 4'b0100,
		SQ_STORE = 4'b1000
	} cms_seq_t;

	typedef enum logic [2:0] {
		PW_RUN = 3'b001,
		PW_HOLD = 3'b010,
		PW_SHDN = 3'b100
	} cms_pwr_t;

	typedef struct packed {
		logic cyc;
		logic stb;
		logic we;
		logic [7:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} cms_wb_req_t;

	typedef struct packed {
		logic wake_tone;
		logic por_ok;
		logic osc_stable;
		logic thermal_sd;
		logic io_ok;
	} cms_pins_t;

	typedef struct packed {
		cms_pins_t pin_s1;
		cms_pins_t pin_s2;
		cms_pwr_t pwr;
		logic [19:0] pwr_cnt;
		logic pd_pend;
		logic pd_flag;
		logic [7:0] cell_count;
		logic [29:0] chan_sel;
		logic [2:0] ovs_code;
		logic ovs_cycled;
		logic [15:0] ovs_hper;
		logic [15:0] ovs_gper;
		logic [15:0] per_cell;
		logic [15:0] per_aux;
		logic [15:0] per_int;
		logic [15:0] off_cell;
		logic [15:0] off_aux;
		cms_seq_t sq;
		logic [4:0] pos;
		logic [5:0] smp;
		logic [15:0] cnt;
		logic [29:0][18:0] acc;
		logic [29:0][15:0] res;
		logic busy;
		logic done;
		logic ack;
		logic [31:0] dat;
		logic [4:0] adc_ch;
		logic [4:0] fe_sel;
		logic hold;
		logic [15:0] comp_en;
		logic [15:0] fault_mask;
		logic pump_en;
		logic reg_en;
		logic core_rst;
	} cms_state_t;

endpackage : cms_pkg

// ---- logic/cms_seq.sv ----
// What this block does
// (RULE1) convert selected cells from the highest numbered down to the lowest
// (RULE2) each conversion is a 14-bit sample with a fixed 3.44 us hold
// (RULE3) a programmable sample interval precedes every conversion; fixed DTEMP_CYC for channel 29, VCORE_CYC for first sample of 28
// (RULE4) mux reaches 16 cells, module, temps, reference, pump rail, 8 aux, core
// (RULE5) single sampling or averaging in one of two modes chosen by one bit
// (RULE6) each channel has its own enable bit, limited by the cell count
// (RULE7) separate sample periods for cells, aux inputs and internal channels
// (RULE8) programmable correction added to cell and aux results
// (RULE9) cell count says how many cells are used, dropped from 16 downward
// (RULE10) cells above the count have faults masked and comparators off
// (RULE11) between sequences the front end rests on the cell count channel
// (RULE12) during measurement the front end addresses the sequencer's cell
// (RULE13) io supply missing holds reset, then shutdown after a delay
// (RULE14) wake from shutdown sets the power-down cause flag
// (RULE15) charge pump runs outside shutdown once oscillator and supplies are good
// (RULE16) charge pump starts ramping when a wake tone arrives
// (RULE17) regulator control is off in shutdown
// (RULE18) host must reset or cycle shutdown if core supply lost regulation
// (RULE19) seventeen sense inputs 0 to 16 bound at most 16 cells
// (RULE20) a command register write starts the measurement sequence
// (RULE21) averaging uses 2, 4, 8, 16 or 32 samples and outputs their mean
// (RULE22) cycled mode samples each channel once per pass, else all at once; the code samples channel 29 (CH_DTEMP) in the first pass only
// (RULE23) after the last channel, return to idle channel and flag done
//
// The Wishbone register port and the address map are this design's own decisions.
`timescale 1ns/100ps
module cms_seq
	import cms_pkg::*;
#(
	parameter logic [19:0] IO_SD_DLY = 20'(IO_SD_DLY_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire cms_wb_req_t wb_req,
	output logic wb_ack_o,
	output logic [31:0] wb_dat_o,
	input wire cms_pins_t pins,
	input wire logic [13:0] adc_data,
	output logic [4:0] adc_ch,
	output logic conv_hold,
	output logic [4:0] fe_cell_sel,
	output logic [15:0] ovuv_comp_en,
	output logic [15:0] ovuv_fault_mask,
	output logic pump_en,
	output logic reg_en,
	output logic core_rst
);

	// ------------------------------------------------------------
	// reset value of the whole state
	// ------------------------------------------------------------
	// supply good is the idle level, so release of reset is no false supply loss
	localparam cms_pins_t RST_PINS = '{io_ok: 1'b1, default: 1'b0};
	localparam cms_state_t RST_STATE = '{
		pin_s1: RST_PINS,
		pin_s2: RST_PINS,
		pwr: PW_RUN,
		sq: SQ_IDLE,
		cell_count: CELL_COUNT_RST,
		chan_sel: CHAN_SEL_RST,
		ovs_hper: OVS_HPER_RST,
		ovs_gper: OVS_GPER_RST,
		per_cell: PER_CELL_RST,
		per_aux: PER_AUX_RST,
		per_int: PER_INT_RST,
		fe_sel: CELL_COUNT_RST[4:0],
		comp_en: 16'hFFFF,
		reg_en: 1'b1,
		default: '0
	};

	cms_state_t r;
	cms_state_t n;
	logic [29:0] en_pos;
	logic [15:0] cmp_on;
	logic [31:0] rv;
	logic [31:0] wm;
	logic wr;
	logic start;
	logic [4:0] ch;
	logic [5:0] nxt;
	logic [5:0] rep;
	logic [5:0] fst;
	logic [2:0] code_eff;
	logic last;
	logic [20:0] scaled;
	logic [15:0] mean;
	logic [5:0] ridx;

	// ------------------------------------------------------------
	// helpers
	// ------------------------------------------------------------
	// (RULE1) cells walked from 16 down
	function automatic logic [4:0] pos2ch(input logic [4:0] p);
		pos2ch = (p < 5'(NCELL)) ? 5'(NCELL - 1) - p : p;
	endfunction : pos2ch

	function automatic logic [5:0] find_pos(input logic [29:0] en, input logic [5:0] from);
		find_pos = 6'h00;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (en[i] && 6'(i) >= from) begin
				find_pos = {1'b1, 5'(i)};
			end
		end
	endfunction : find_pos

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] s);
		for (int i = 0; i < 4; i++) begin
			merge[8*i +: 8] = s[i] ? d[8*i +: 8] : old[8*i +: 8];
		end
	endfunction : merge

	// (RULE7) period per input class and sample
	function automatic logic [15:0] period(input cms_state_t s, input logic [4:0] c,
		input logic first);
		if (c < 5'(CH_AUX0)) begin
			period = (first || s.ovs_cycled) ? s.per_cell : s.ovs_hper;
		end else if (c < 5'(CH_MODULE)) begin
			period = (first || s.ovs_cycled) ? s.per_aux : s.ovs_gper;
		end else if (c == 5'(CH_DTEMP)) begin
			period = 16'(DTEMP_CYC);
		end else if (c == 5'(CH_VCORE)) begin
			period = first ? 16'(VCORE_CYC) : s.ovs_gper;
		end else begin
			period = first ? s.per_int : s.ovs_hper;
		end
	endfunction : period

	// ------------------------------------------------------------
	// per channel enables
	// ------------------------------------------------------------
	for (genvar g = 0; g < NCH; g++) begin : g_pos
		localparam int CH = (g < NCELL) ? NCELL - 1 - g : g;
		// (RULE6) own bit gated by cell count
		assign en_pos[g] = r.chan_sel[CH] && (CH >= NCELL || 8'(CH) < r.cell_count);
	end

	for (genvar g = 0; g < NCELL; g++) begin : g_cmp
		// (RULE10) comparators off above count
		assign cmp_on[g] = 8'(g) < r.cell_count;
	end

	// ------------------------------------------------------------
	// register read view
	// ------------------------------------------------------------
	always_comb begin
		rv = 32'h0000_0000;
		ridx = wb_req.adr[7:2] - 6'h10;
		unique case (wb_req.adr)
			OFS_CELL_COUNT: rv = {24'h000000, r.cell_count};
			OFS_CHAN_SEL: rv = {2'b00, r.chan_sel};
			OFS_OVS_CFG: rv = {r.ovs_gper[7:0], r.ovs_hper[7:0], 12'h000, r.ovs_cycled,
				r.ovs_code};
			OFS_PER_CELL: rv = {16'h0000, r.per_cell};
			OFS_PER_AUX: rv = {16'h0000, r.per_aux};
			OFS_PER_INT: rv = {16'h0000, r.per_int};
			OFS_OFF_CELL: rv = {16'h0000, r.off_cell};
			OFS_OFF_AUX: rv = {16'h0000, r.off_aux};
			OFS_STATUS: rv = {26'h0000000, r.core_rst, r.reg_en, r.pump_en,
				r.pwr == PW_SHDN, r.done, r.busy};
			OFS_SHUTDOWN_STATUS: rv = {31'h00000000, r.pd_flag};
			default: begin
				if (wb_req.adr >= OFS_RESULT0 && ridx < 6'(NCH)) begin
					rv = {16'h0000, r.res[ridx[4:0]]};
				end
			end
		endcase
	end

	// ------------------------------------------------------------
	// next state
	// ------------------------------------------------------------
	always_comb begin
		n = r;
		n.pin_s1 = pins;
		n.pin_s2 = r.pin_s1;
		// answer one cycle after the request, take write on the ack edge
		n.ack = wb_req.cyc && wb_req.stb && !r.ack;
		n.dat = n.ack ? rv : 32'h0000_0000;
		wr = wb_req.cyc && wb_req.stb && wb_req.we && r.ack;
		wm = merge(rv, wb_req.dat, wb_req.sel);
		start = 1'b0;
		ch = pos2ch(r.pos);
		code_eff = (ch == 5'(CH_DTEMP)) ? 3'h0 : r.ovs_code;
		// (RULE21) sample count 1 to 32
		last = r.smp == 6'((1 << code_eff) - 1);
		// (RULE21) mean keeps two extra bits
		scaled = {r.acc[ch], 2'b00} >> code_eff;
		mean = scaled[15:0];
		// (RULE8) correction on cell and aux results
		if (ch < 5'(CH_AUX0)) begin
			mean = mean + r.off_cell;
		end else if (ch < 5'(CH_MODULE)) begin
			mean = mean + r.off_aux;
		end
		nxt = find_pos(en_pos, 6'(r.pos) + 6'h01);
		rep = find_pos({1'b0, en_pos[28:0]}, 6'h00);
		fst = find_pos(en_pos, 6'h00);

		if (wr) begin
			unique case (wb_req.adr)
				// (RULE20) command write starts sequence
				OFS_CMD: start = wb_req.sel[0] && wb_req.dat[0];
				OFS_CELL_COUNT: begin
					// (RULE19) at most 16 cells on inputs 0 to 16
					n.cell_count = (wm[7:0] > 8'(NCELL)) ? 8'(NCELL) : wm[7:0];
				end
				OFS_CHAN_SEL: n.chan_sel = wm[29:0];
				OFS_OVS_CFG: begin
					n.ovs_code = (wm[2:0] > 3'(MAX_OVS_CODE)) ? 3'(MAX_OVS_CODE) : wm[2:0];
					// (RULE5) averaging mode select
					n.ovs_cycled = wm[3];
					n.ovs_hper = {8'h00, wm[23:16]};
					n.ovs_gper = {8'h00, wm[31:24]};
				end
				OFS_PER_CELL: n.per_cell = wm[15:0];
				OFS_PER_AUX: n.per_aux = wm[15:0];
				OFS_PER_INT: n.per_int = wm[15:0];
				OFS_OFF_CELL: n.off_cell = wm[15:0];
				OFS_OFF_AUX: n.off_aux = wm[15:0];
				OFS_STATUS: n.done = r.done && !(wb_req.sel[0] && wb_req.dat[1]);
				OFS_SHUTDOWN_STATUS: n.pd_flag = r.pd_flag && !(wb_req.sel[0] && wb_req.dat[0]);
				default: ;
			endcase
		end

		// ------------------------------------------------------------
		// sequencer
		// ------------------------------------------------------------
		unique case (r.sq)
			SQ_IDLE: begin
				if (start && !r.busy) begin
					n.acc = '0;
					n.smp = 6'h00;
					if (!fst[5]) begin
						n.done = 1'b1;
					end else begin
						n.pos = fst[4:0];
						n.busy = 1'b1;
						n.sq = SQ_ACQ;
						n.cnt = period(r, pos2ch(n.pos), 1'b1);
					end
				end
			end
			SQ_ACQ: begin
				// (RULE3) settling interval before hold
				n.cnt = r.cnt - 16'h0001;
				if (r.cnt <= 16'h0001) begin
					n.sq = SQ_HOLD;
					// (RULE2) fixed hold time
					n.cnt = 16'(HOLD_CYC);
				end
			end
			SQ_HOLD: begin
				n.cnt = r.cnt - 16'h0001;
				if (r.cnt == 16'h0001) begin
					n.acc[ch] = r.acc[ch] + 19'(adc_data);
					n.sq = SQ_STORE;
				end
			end
			SQ_STORE: begin
				n.sq = SQ_ACQ;
				if (!r.ovs_cycled) begin
					// (RULE22) all samples of one channel first
					if (!last) begin
						n.smp = r.smp + 6'h01;
						n.cnt = period(r, ch, 1'b0);
					end else begin
						n.res[ch] = mean;
						n.smp = 6'h00;
						n.pos = nxt[4:0];
						n.cnt = period(r, pos2ch(nxt[4:0]), 1'b1);
						if (!nxt[5]) begin
							n.sq = SQ_IDLE;
						end
					end
				end else begin
					// (RULE22) one sample per channel per pass, CH_DTEMP in the first pass only
					if (last || ch == 5'(CH_DTEMP)) begin
						n.res[ch] = mean;
					end
					if (nxt[5] && !(r.smp != 6'h00 && nxt[4:0] == 5'(CH_DTEMP))) begin
						n.pos = nxt[4:0];
						n.cnt = period(r, pos2ch(nxt[4:0]), r.smp == 6'h00);
					end else if (r.smp != 6'((1 << r.ovs_code) - 1) && rep[5]) begin
						n.smp = r.smp + 6'h01;
						n.pos = rep[4:0];
						n.cnt = period(r, pos2ch(rep[4:0]), 1'b0);
					end else begin
						n.sq = SQ_IDLE;
					end
				end
				if (n.sq == SQ_IDLE) begin
					// (RULE23) sequence complete
					n.busy = 1'b0;
					n.done = 1'b1;
				end
			end
		endcase

		// ------------------------------------------------------------
		// power states
		// ------------------------------------------------------------
		unique case (r.pwr)
			PW_RUN: begin
				if (r.pin_s2.thermal_sd) begin
					n.pwr = PW_SHDN;
					n.pd_pend = 1'b1;
				end else if (!r.pin_s2.io_ok) begin
					n.pwr = PW_HOLD;
					n.pwr_cnt = 20'h00000;
				end
			end
			PW_HOLD: begin
				// (RULE13) held in reset, shutdown after delay
				n.pwr_cnt = r.pwr_cnt + 20'h00001;
				if (r.pin_s2.io_ok) begin
					n.pwr = PW_RUN;
				end else if (r.pwr_cnt >= IO_SD_DLY - 20'h00001) begin
					n.pwr = PW_SHDN;
					n.pd_pend = 1'b1;
				end
			end
			PW_SHDN: begin
				if (r.pin_s2.wake_tone && r.pin_s2.io_ok && !r.pin_s2.thermal_sd) begin
					n.pwr = PW_RUN;
					// (RULE14) cause flag on wake, set beats clear
					n.pd_flag = n.pd_flag || r.pd_pend;
					n.pd_pend = 1'b0;
				end
			end
		endcase

		// (RULE13) internal reset while supply is not good
		if (n.pwr != PW_RUN) begin
			n.cell_count = RST_STATE.cell_count;
			n.chan_sel = RST_STATE.chan_sel;
			n.sq = SQ_IDLE;
			n.busy = 1'b0;
			n.done = 1'b0;
			n.acc = '0;
		end
		n.core_rst = n.pwr != PW_RUN;
		// (RULE17) regulator off in shutdown
		n.reg_en = n.pwr != PW_SHDN;
		// (RULE15) pump needs oscillator and supplies; (RULE16) wake tone starts it
		n.pump_en = r.pin_s2.osc_stable && r.pin_s2.por_ok &&
			(n.pwr != PW_SHDN || r.pin_s2.wake_tone);

		// (RULE4) converter source is the channel index
		n.adc_ch = (n.sq == SQ_IDLE) ? 5'(n.cell_count - 8'h01) : pos2ch(n.pos);
		n.hold = n.sq == SQ_HOLD;
		// (RULE11) idle and non-cell channels rest on cell count; (RULE12) measured cell otherwise
		if (n.sq == SQ_IDLE || pos2ch(n.pos) >= 5'(NCELL)) begin
			n.fe_sel = n.cell_count[4:0];
		end else begin
			n.fe_sel = pos2ch(n.pos) + 5'h01;
		end
		// (RULE9) (RULE10) cells above count off
		n.comp_en = (n.pwr == PW_RUN) ? cmp_on : 16'h0000;
		n.fault_mask = ~n.comp_en;
	end

	// ------------------------------------------------------------
	// state register
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			r <= RST_STATE;
		end else if (ce) begin
			r <= n;
		end
	end

	assign wb_ack_o = r.ack;
	assign wb_dat_o = r.dat;
	assign adc_ch = r.adc_ch;
	assign conv_hold = r.hold;
	assign fe_cell_sel = r.fe_sel;
	assign ovuv_comp_en = r.comp_en;
	assign ovuv_fault_mask = r.fault_mask;
	assign pump_en = r.pump_en;
	assign reg_en = r.reg_en;
	assign core_rst = r.core_rst;

endmodule : cms_seq

// ---- verification/cms_seq_props.sv ----
`timescale 1ns/100ps
module cms_seq_props
	import cms_pkg::*;
#(
	parameter logic [19:0] IO_SD_DLY = 20'(IO_SD_DLY_CYC)
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	input wire cms_wb_req_t wb_req,
	input wire logic wb_ack_o,
	input wire logic [31:0] wb_dat_o,
	input wire cms_pins_t pins,
	input wire logic [13:0] adc_data,
	input wire logic [4:0] adc_ch,
	input wire logic conv_hold,
	input wire logic [4:0] fe_cell_sel,
	input wire logic [15:0] ovuv_comp_en,
	input wire logic [15:0] ovuv_fault_mask,
	input wire logic pump_en,
	input wire logic reg_en,
	input wire logic core_rst
);
	logic [5:0] hold_cnt_reg;
	logic [21:0] io_low_reg;
	// the io low counter saturates so a long outage never wraps back below the limit
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hold_cnt_reg <= 6'h00;
			io_low_reg <= 22'h000000;
		end else begin
			hold_cnt_reg <= conv_hold ? hold_cnt_reg + 6'h01 : 6'h00;
			io_low_reg <= pins.io_ok ? 22'h000000 : io_low_reg + 22'(~&io_low_reg);
		end
	end
	default clocking dc @(posedge clk); endclocking
	default disable iff (rst);
	AST_HOLD_LEN: assert property ($fell(conv_hold) |-> hold_cnt_reg == 6'h23)
		else $error("hold phase not 35 cycles");
	AST_ACQ_GAP: assert property ($fell(conv_hold) |-> !conv_hold [*2])
		else $error("no acquisition gap after conversion");
	AST_MUX_STABLE: assert property (conv_hold && $past(conv_hold) |->
		$stable(adc_ch) && $stable(fe_cell_sel)) else $error("mux moved during hold");
	AST_MASK_INV: assert property (ovuv_fault_mask == ~ovuv_comp_en)
		else $error("fault mask not inverse of comparator enable");
	AST_ACK_TIME: assert property (ce && wb_req.cyc && wb_req.stb && !wb_ack_o |=> wb_ack_o)
		else $error("bus ack late");
	AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("bus ack longer than one cycle");
	AST_PUMP_WAKE: assert property ((pins.wake_tone && pins.osc_stable && pins.por_ok) [*5]
		|-> pump_en) else $error("pump off during wake tone");
	AST_PUMP_OFF: assert property ((!reg_en && !pins.wake_tone) [*5] |-> !$past(pump_en))
		else $error("pump on in shutdown");
	AST_REG_SHDN: assert property (io_low_reg > 22'(IO_SD_DLY) + 22'h8 |-> !reg_en)
		else $error("regulator on after io supply loss");
	cover property ($fell(conv_hold));
	cover property (!reg_en ##1 reg_en);
	cover property (wb_ack_o && wb_req.we);
endmodule : cms_seq_props

bind cms_seq cms_seq_props #(.IO_SD_DLY(IO_SD_DLY)) u_cms_seq_props (.clk(clk), .rst(rst),
	.ce(ce), .wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pins(pins),
	.adc_data(adc_data), .adc_ch(adc_ch), .conv_hold(conv_hold), .fe_cell_sel(fe_cell_sel),
	.ovuv_comp_en(ovuv_comp_en), .ovuv_fault_mask(ovuv_fault_mask), .pump_en(pump_en),
	.reg_en(reg_en), .core_rst(core_rst));

// ---- verification/cms_adc_model.sv ----
`timescale 1ns/100ps
module cms_adc_model (
	input wire logic clk,
	input wire logic [4:0] adc_ch,
	input wire logic conv_hold,
	output logic [13:0] adc_data
);
	logic [13:0] noise_reg = 14'h0000;
	// outside hold the value churns so a stray sample is never a lucky match
	always_ff @(posedge clk) begin
		noise_reg <= noise_reg + 14'h1555;
	end
	assign adc_data = conv_hold ? {adc_ch, 9'h0A5} : noise_reg;
endmodule : cms_adc_model

// ---- verification/cms_seq_test.sv ----
`timescale 1ns/100ps
module cms_seq_test
	import cms_pkg::*;
;
	logic clk, rst, wb_ack_o, conv_hold, pump_en, reg_en, core_rst, hold_d;
	cms_wb_req_t wb_req;
	cms_pins_t pins;
	logic [31:0] wb_dat_o, rd;
	logic [13:0] adc_data;
	logic [4:0] adc_ch, fe_cell_sel;
	logic [15:0] ovuv_comp_en, ovuv_fault_mask;
	logic [4:0] seen_q[$];
	int error_cnt = 0;
	int samples_checked = 0;

	cms_seq #(.IO_SD_DLY(20'h00014)) u_cms_seq (.clk(clk), .rst(rst), .ce(1'b1),
		.wb_req(wb_req), .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .pins(pins),
		.adc_data(adc_data), .adc_ch(adc_ch), .conv_hold(conv_hold), .fe_cell_sel(fe_cell_sel),
		.ovuv_comp_en(ovuv_comp_en), .ovuv_fault_mask(ovuv_fault_mask), .pump_en(pump_en),
		.reg_en(reg_en), .core_rst(core_rst));
	cms_adc_model u_cms_adc_model (.clk(clk), .adc_ch(adc_ch), .conv_hold(conv_hold),
		.adc_data(adc_data));

	// ----
	// helpers
	// ----
	task automatic end_sim;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : end_sim

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", what, exp, seen);
			error_cnt++;
		end
	endtask : chk

	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: w, adr: a, sel: 4'hF, dat: d};
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (wb_ack_o !== 1'b1 && n < 50);
		if (wb_ack_o !== 1'b1) chk("bus ack", 0, 1);
		rd = wb_dat_o;
		wb_req.cyc <= 1'b0;
		wb_req.stb <= 1'b0;
	endtask : wb

	task automatic run_seq(input logic [2:0] code, input logic cyc);
		int chs[$];
		int exp_q[$];
		logic [31:0] sel;
		logic [15:0] offc, offa;
		int n, k;
		sel = ($urandom & 32'h3FFF) | 32'h18000;
		offc = 16'($urandom);
		offa = 16'($urandom);
		wb(1, OFS_CHAN_SEL, sel);
		wb(1, OFS_OFF_CELL, {16'h0000, offc});
		wb(1, OFS_OFF_AUX, {16'h0000, offa});
		wb(1, OFS_OVS_CFG, {8'h02, 8'h02, 12'h000, cyc, code});
		wb(0, OFS_OVS_CFG, 32'h0);
		chk("ovs cfg", rd, {8'h02, 8'h02, 12'h000, cyc, code});
		for (k = 13; k >= 0; k--) if (sel[k]) chs.push_back(k);
		chs.push_back(16);
		n = (code == 3'h0) ? 1 : (1 << code);
		for (k = 0; k < (cyc ? n : 1); k++) begin
			foreach (chs[i]) repeat (cyc ? 1 : n) exp_q.push_back(chs[i]);
		end
		seen_q.delete();
		wb(1, OFS_CMD, 32'h1);
		wb(1, OFS_CMD, 32'h1);
		wb(0, OFS_STATUS, 32'h0);
		chk("busy", rd[0], 1);
		for (k = 0; k < 3000 && rd[1] !== 1'b1; k++) wb(0, OFS_STATUS, 32'h0);
		chk("status", rd[1:0], 2'b10);
		chk("count", seen_q.size(), exp_q.size());
		foreach (exp_q[i]) chk("order", seen_q[i], exp_q[i]);
		foreach (chs[i]) begin
			wb(0, OFS_RESULT0 + 8'(4 * chs[i]), 32'h0);
			chk("result", rd, {16'h0000, 16'(4 * ((chs[i] << 9) + 'h0A5)
				+ (chs[i] == 16 ? offa : offc))});
		end
		wb(1, OFS_STATUS, 32'h2);
		repeat (2) @(posedge clk);
		chk("idle cell", fe_cell_sel, 14);
		chk("idle ch", adc_ch, 13);
		$display("test sequence code %0d cycled %0d done", code, cyc);
	endtask : run_seq

	// ----
	// stimulus
	// ----
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (conv_hold === 1'b1 && hold_d !== 1'b1) begin
			seen_q.push_back(adc_ch);
			if (adc_ch < 5'h10) chk("measured cell", fe_cell_sel, adc_ch + 5'h01);
		end
		hold_d <= conv_hold;
	end

	initial begin
		#(100 * 80000);
		error_cnt++;
		end_sim();
	end

	initial begin
		logic [7:0] ofs[5] = '{OFS_CELL_COUNT, OFS_CHAN_SEL, OFS_PER_CELL, OFS_PER_AUX, OFS_PER_INT};
		logic [31:0] rv[5] = '{32'h10, 32'hFFFF, 32'h258, 32'h7E, 32'h3E8};
		int n;
		rst = 1'b1;
		wb_req = '0;
		pins = '{wake_tone: 1'b0, por_ok: 1'b1, osc_stable: 1'b1, thermal_sd: 1'b0, io_ok: 1'b1};
		void'($urandom(8));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		chk("comp en", ovuv_comp_en, 16'hFFFF);
		chk("idle sel", fe_cell_sel, 16);
		foreach (ofs[i]) begin
			wb(0, ofs[i], 32'h0);
			chk("reset value", rd, rv[i]);
		end
		wb(1, 8'h3C, 32'hFFFFFFFF);
		wb(0, 8'h3C, 32'h0);
		chk("unmapped", rd, 0);
		wb(1, OFS_CELL_COUNT, 32'h20);
		wb(0, OFS_CELL_COUNT, 32'h0);
		chk("count clamp", rd, 32'h10);
		wb(1, OFS_CELL_COUNT, 32'h0E);
		wb(1, OFS_PER_CELL, 32'h2);
		wb(1, OFS_PER_AUX, 32'h2);
		repeat (2) @(posedge clk);
		chk("comp en 14", ovuv_comp_en, 16'h3FFF);
		chk("mask 14", ovuv_fault_mask, 16'hC000);
		chk("idle 14", fe_cell_sel, 14);
		$display("test registers done");
		for (int c = 0; c < 4; c++) run_seq(c[1] ? 3'h2 : 3'h0, c[0]);
		pins.io_ok <= 1'b0;
		for (n = 0; n < 200 && reg_en !== 1'b0; n++) @(posedge clk);
		repeat (6) @(posedge clk);
		chk("reg off", reg_en, 0);
		chk("pump off", pump_en, 0);
		chk("core held", core_rst, 1);
		pins.wake_tone <= 1'b1;
		repeat (5) @(posedge clk);
		chk("pump wake", pump_en, 1);
		// host restores with shutdown then wake
		pins.io_ok <= 1'b1;
		for (n = 0; n < 200 && (reg_en !== 1'b1 || core_rst !== 1'b0); n++) @(posedge clk);
		pins.wake_tone <= 1'b0;
		repeat (3) @(posedge clk);
		chk("core run", core_rst, 0);
		wb(0, OFS_SHUTDOWN_STATUS, 32'h0);
		chk("cause flag", rd, 1);
		wb(1, OFS_SHUTDOWN_STATUS, 32'h1);
		wb(0, OFS_SHUTDOWN_STATUS, 32'h0);
		chk("flag clear", rd, 0);
		wb(0, OFS_CELL_COUNT, 32'h0);
		chk("count restored", rd, 32'h10);
		$display("test power done");
		end_sim();
	end
endmodule : cms_seq_test
